// *** pkg/adc_sel_consts.svh ***
`ifndef ADC_SEL_CONSTS_SVH
`define ADC_SEL_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map (word addresses on the plain register port)
// ----------------------------------------------------------------------
`define ADDR_SELECT      4'h0
`define ADDR_RESULT_LOW  4'h1
`define ADDR_RESULT_HIGH 4'h2
`define ADDR_STATUS      4'h3
`define SELECT_RESET     8'h00

// ----------------------------------------------------------------------
// Selection register fields
// ----------------------------------------------------------------------
`define REF_MSB          7
`define REF_LSB          6
`define ALIGN_BIT        5
`define CHAN_MSB         4
`define CHAN_LSB         0

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define STAT_DONE_BIT    0
`define STAT_BUSY_BIT    1
`define STAT_LOCK_BIT    2

// ----------------------------------------------------------------------
// Result coding
// ----------------------------------------------------------------------
`define SE_MAX_CODE      10'h3ff
`define DIFF_MAX_CODE    10'h1ff
`define DIFF_MIN_CODE    10'h200
`define SE_SCALE         12'h400
`define DIFF_SCALE       12'h200
`define LEFT_PAD         6

// ----------------------------------------------------------------------
// Channel code groups
// ----------------------------------------------------------------------
`define CHAN_BANDGAP     5'h1e
`define CHAN_GROUND      5'h1f
`define CHAN_NEG2_LAST   5'h1d
`define GAIN_X1          8'h01
`define GAIN_X10         8'h0a
`define GAIN_X200        8'hc8

`endif

// *** pkg/adc_sel_pkg.sv ***
package adc_sel_pkg;

    // Reference source choice.
    typedef enum logic [1:0] {
        REF_EXTERNAL_PIN = 2'b00,
        REF_ANALOG_SUPPLY = 2'b01,
        REF_RESERVED     = 2'b10,
        REF_INTERNAL_256 = 2'b11
    } reference_t;

    // Selection register contents.
    typedef struct packed {
        reference_t reference_select;
        logic       left_adjust_result;
        logic [4:0] channel_gain_select;
    } select_t;

    // Decoded routing towards the analog front end.
    typedef struct packed {
        logic       differential;
        logic [2:0] pos_channel;
        logic [2:0] neg_channel;
        logic [7:0] gain;
        logic       bandgap;
        logic       ground;
    } route_t;

endpackage

// *** verilog/adc_route_decode.sv ***
`timescale 1ns/1ps
`include "adc_sel_consts.svh"

module adc_route_decode (
    input  wire logic [4:0]          i_chan,
    output adc_sel_pkg::route_t      o_route
);

    // Channel field decode: single-ended, gain pairs, 1x pairs, internals.
    always_comb begin
        o_route = '0;
        o_route.gain = `GAIN_X1;
        case (i_chan[4:3])
            2'b00: begin
                o_route.pos_channel = i_chan[2:0];
            end
            2'b01: begin
                // Pairs: pos 0/1 vs neg 0, or pos 2/3 vs neg 2.
                o_route.differential = 1'b1;
                o_route.pos_channel  = {1'b0, i_chan[2], i_chan[0]};
                o_route.neg_channel  = {1'b0, i_chan[2], 1'b0};
                o_route.gain = i_chan[1] ? `GAIN_X200 : `GAIN_X10;
            end
            2'b10: begin
                o_route.differential = 1'b1;
                o_route.pos_channel  = i_chan[2:0];
                o_route.neg_channel  = 3'h1;
            end
            default: begin
                if (i_chan == `CHAN_BANDGAP) begin
                    o_route.bandgap = 1'b1;
                end else if (i_chan == `CHAN_GROUND) begin
                    o_route.ground = 1'b1;
                end else begin
                    o_route.differential = 1'b1;
                    o_route.pos_channel  = i_chan[2:0];
                    o_route.neg_channel  = 3'h2;
                end
            end
        endcase
    end

endmodule

// *** verilog/adc_code_format.sv ***
`timescale 1ns/1ps
`include "adc_sel_consts.svh"

module adc_code_format (
    input  wire logic               i_differential,
    input  wire logic signed [11:0] i_raw,
    output logic [9:0]              o_code
);

    // Clamp the raw converter value into the 10-bit field. The raw input
    // is two bits wider than the field so overrange is seen, not wrapped.
    always_comb begin
        if (!i_differential) begin
            if (i_raw < 0) begin
                o_code = 10'h000;
            end else if (i_raw > $signed({2'b00, `SE_MAX_CODE})) begin
                o_code = `SE_MAX_CODE;
            end else begin
                o_code = i_raw[9:0];
            end
        end else begin
            if (i_raw > $signed({2'b00, `DIFF_MAX_CODE})) begin
                o_code = `DIFF_MAX_CODE;
            end else if (i_raw < -$signed({2'b00, `DIFF_MIN_CODE})) begin
                o_code = `DIFF_MIN_CODE;
            end else begin
                o_code = i_raw[9:0];
            end
        end
    end

endmodule

// *** verilog/adc_select_format.sv ***
`timescale 1ns/1ps
`include "adc_sel_consts.svh"

module adc_select_format #(
    parameter int RAW_WIDTH = 12
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic [3:0]            i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    input  wire logic                  i_conv_start,
    input  wire logic                  i_conv_done,
    input  wire logic signed [11:0]    i_conv_raw,
    output logic [7:0]                 o_rdata,
    output adc_sel_pkg::route_t        o_route,
    output adc_sel_pkg::reference_t    o_reference,
    output logic                       o_int_ref_enable,
    output logic                       o_conv_busy,
    output logic                       o_done_flag
);

    // The clamp compares against a 12-bit raw value; refuse other widths.
    if (RAW_WIDTH != $bits(i_conv_raw)) begin : g_bad_raw_width
        $error("RAW_WIDTH must match the raw input width");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    adc_sel_pkg::select_t      select_reg, select_next;
    adc_sel_pkg::reference_t   ref_active_reg, ref_active_next;
    logic [4:0]                chan_active_reg, chan_active_next;
    logic                      busy_reg, busy_next;
    logic                      done_reg, done_next;
    logic                      lock_reg, lock_next;
    logic                      pend_reg, pend_next;
    logic [9:0]                result_reg, result_next;
    logic [9:0]                pend_code_reg, pend_code_next;
    logic [7:0]                rdata_reg, rdata_next;
    adc_sel_pkg::route_t       route_reg, route_next;
    logic                      intref_reg, intref_next;

    adc_sel_pkg::route_t       route_dec;
    logic [9:0]                code_fmt;
    logic [15:0]               presented;
    logic                      wr_status_clear;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Routing is decoded from the settings latched for the conversion.
    adc_route_decode u_decode (
        .i_chan  (chan_active_next),
        .o_route (route_dec)
    );

    adc_code_format u_format (
        .i_differential (route_reg.differential),
        .i_raw          (i_conv_raw),
        .o_code         (code_fmt)
    );

    // Presentation follows the live alignment bit, never a latched copy,
    // so a flip of the bit is visible on the very next read.
    always_comb begin
        if (select_reg.left_adjust_result) begin
            presented = {result_reg, {`LEFT_PAD{1'b0}}};
        end else begin
            presented = {6'h00, result_reg};
        end
    end

    assign wr_status_clear = i_wr && (i_addr == `ADDR_STATUS)
                           && i_wdata[`STAT_DONE_BIT];

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        select_next      = select_reg;
        ref_active_next  = ref_active_reg;
        chan_active_next = chan_active_reg;
        busy_next        = busy_reg;
        done_next        = done_reg;
        lock_next        = lock_reg;
        pend_next        = pend_reg;
        result_next      = result_reg;
        pend_code_next   = pend_code_reg;
        rdata_next       = 8'h00;

        if (i_wr && (i_addr == `ADDR_SELECT)) begin
            select_next = adc_sel_pkg::select_t'(i_wdata);
        end

        // Settings are taken over while idle or in the done cycle; a write during a
        // conversion waits in select_reg until it has finished.
        if (!busy_reg || i_conv_done) begin
            ref_active_next  = select_next.reference_select;
            chan_active_next = select_next.channel_gain_select;
        end

        if (i_conv_start && !busy_reg) begin
            busy_next = 1'b1;
        end

        if (wr_status_clear) begin
            done_next = 1'b0;
        end

        // Read side effects on the result pair.
        if (i_rd && (i_addr == `ADDR_RESULT_LOW)) begin
            lock_next = 1'b1;
        end
        if (i_rd && (i_addr == `ADDR_RESULT_HIGH)) begin
            lock_next = 1'b0;
            if (pend_reg) begin
                result_next = pend_code_reg;
                pend_next   = 1'b0;
            end
        end

        // A finished conversion lands in the result unless a byte pair read
        // is open or opens in this cycle; then it is parked and delivered
        // when the pair closes, so the two bytes never mix two results.
        if (busy_reg && i_conv_done) begin
            busy_next = 1'b0;
            done_next = 1'b1;
            if ((lock_reg || (i_rd && (i_addr == `ADDR_RESULT_LOW)))
                && !(i_rd && (i_addr == `ADDR_RESULT_HIGH))) begin
                pend_next      = 1'b1;
                pend_code_next = code_fmt;
            end else begin
                result_next = code_fmt;
                pend_next   = 1'b0;
            end
        end

        case (i_addr)
            `ADDR_SELECT:      rdata_next = select_reg;
            `ADDR_RESULT_LOW:  rdata_next = presented[7:0];
            `ADDR_RESULT_HIGH: rdata_next = presented[15:8];
            `ADDR_STATUS: begin
                rdata_next[`STAT_DONE_BIT] = done_reg;
                rdata_next[`STAT_BUSY_BIT] = busy_reg;
                rdata_next[`STAT_LOCK_BIT] = lock_reg;
            end
            default:           rdata_next = 8'h00;
        endcase
        if (!i_rd) begin
            rdata_next = 8'h00;
        end

        // Reference decode: internal source only for code 11.
        route_next  = route_dec;
        intref_next = (ref_active_next == adc_sel_pkg::REF_INTERNAL_256);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            select_reg      <= adc_sel_pkg::select_t'(`SELECT_RESET);
            ref_active_reg  <= adc_sel_pkg::REF_EXTERNAL_PIN;
            chan_active_reg <= 5'h00;
            busy_reg        <= 1'b0;
            done_reg        <= 1'b0;
            lock_reg        <= 1'b0;
            pend_reg        <= 1'b0;
            result_reg      <= 10'h000;
            pend_code_reg   <= 10'h000;
            rdata_reg       <= 8'h00;
            route_reg       <= '0;
            intref_reg      <= 1'b0;
        end else begin
            select_reg      <= select_next;
            ref_active_reg  <= ref_active_next;
            chan_active_reg <= chan_active_next;
            busy_reg        <= busy_next;
            done_reg        <= done_next;
            lock_reg        <= lock_next;
            pend_reg        <= pend_next;
            result_reg      <= result_next;
            pend_code_reg   <= pend_code_next;
            rdata_reg       <= rdata_next;
            route_reg       <= route_next;
            intref_reg      <= intref_next;
        end
    end

    assign o_rdata          = rdata_reg;
    assign o_route          = route_reg;
    assign o_reference      = ref_active_reg;
    assign o_int_ref_enable = intref_reg;
    assign o_conv_busy      = busy_reg;
    assign o_done_flag      = done_reg;

endmodule

// *** verif/adc_select_format_props.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the selection and result block
// ----------------------------------------------------------------
module adc_select_format_props (
    input wire logic                    i_clk,
    input wire logic                    i_rst_n,
    input wire logic [3:0]              i_addr,
    input wire logic [7:0]              i_wdata,
    input wire logic                    i_wr,
    input wire logic                    i_rd,
    input wire logic                    i_conv_start,
    input wire logic                    i_conv_done,
    input wire logic [7:0]              o_rdata,
    input wire adc_sel_pkg::route_t     o_route,
    input wire adc_sel_pkg::reference_t o_reference,
    input wire logic                    o_int_ref_enable,
    input wire logic                    o_conv_busy,
    input wire logic                    o_done_flag
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // Status write that clears the sticky flag, and selection writes.
    logic clr_req;
    logic sel_wr;
    assign clr_req = i_wr && i_addr == 4'h3 && i_wdata[0];
    assign sel_wr = i_wr && i_addr == 4'h0;

    sequence s_start;  i_conv_start && !o_conv_busy;  endsequence
    sequence s_finish; o_conv_busy && i_conv_done;    endsequence
    // An idle write followed by a quiet cycle, so the value can settle.
    sequence s_idle_sel;
        (sel_wr && !o_conv_busy && !i_conv_start)
        ##1 !(sel_wr || i_conv_start);
    endsequence

    chk_read_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside answer cycle");
    chk_busy_start: assert property (s_start |=> o_conv_busy)
        else $error("start not taken");
    chk_done_set: assert property (s_finish |=> o_done_flag && !o_conv_busy)
        else $error("done flag not raised");
    chk_done_hold: assert property (o_done_flag && !clr_req |=> o_done_flag)
        else $error("done flag dropped");
    chk_done_clear: assert property (o_done_flag && clr_req && !o_conv_busy
        |=> !o_done_flag)
        else $error("done flag not cleared");
    chk_sel_frozen: assert property (o_conv_busy && !i_conv_done
        |=> $stable(o_reference) && $stable(o_route))
        else $error("routing changed mid conversion");
    chk_sel_apply: assert property (s_idle_sel
        |=> o_reference == $past(i_wdata[7:6], 2))
        else $error("reference not applied");
    chk_int_ref: assert property (o_int_ref_enable
        == (o_reference == adc_sel_pkg::REF_INTERNAL_256))
        else $error("internal reference enable wrong");
    chk_gain_legal: assert property (o_route.differential
        |-> o_route.gain inside {8'h01, 8'h0a, 8'hc8})
        else $error("illegal gain");
    chk_fixed_single: assert property (o_route.bandgap || o_route.ground
        |-> !o_route.differential)
        else $error("fixed source marked differential");
endmodule

bind adc_select_format adc_select_format_props adc_select_format_props_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_conv_start(i_conv_start),
    .i_conv_done(i_conv_done), .o_rdata(o_rdata), .o_route(o_route),
    .o_reference(o_reference), .o_int_ref_enable(o_int_ref_enable),
    .o_conv_busy(o_conv_busy), .o_done_flag(o_done_flag));

// *** verif/adc_analog_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Analog core and input sources
// ----------------------------------------------------------------
module adc_analog_model #(
    parameter int VREF_MV = 2560,
    parameter int LATENCY = 6
) (
    input  wire logic                i_clk,
    input  wire logic                i_start,
    input  wire adc_sel_pkg::route_t i_route,
    output logic                     o_done = 1'b0,
    output logic signed [11:0]       o_raw = 12'h000
);
    int mv [8];
    int cnt = 0;

    // One reference for all codes; reference choice is not modelled.
    function automatic logic signed [11:0] sample(adc_sel_pkg::route_t r);
        int v;
        if (r.ground) v = 0;
        else if (r.bandgap) v = 1220 * 1024 / VREF_MV;
        else if (r.differential)
            v = (mv[r.pos_channel] - mv[r.neg_channel]) * int'(r.gain)
                * 512 / VREF_MV;
        else v = mv[r.pos_channel] * 1024 / VREF_MV;
        if (v > 2047) v = 2047;
        if (v < -2048) v = -2048;
        return v[11:0];
    endfunction

    // Raw lines toggle outside the done cycle so stale data never matches.
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        o_raw <= ~o_raw;
        if (cnt == 0 && i_start) cnt <= LATENCY;
        else if (cnt == 1) begin
            o_done <= 1'b1;
            o_raw <= sample(i_route);
            cnt <= 0;
        end
        else if (cnt > 1) cnt <= cnt - 1;
    end
endmodule

// *** verif/adc_select_format_tb.sv ***
`timescale 1ns/1ps
module adc_select_format_tb;
    typedef struct { logic [7:0] sel; logic [9:0] code; } row_t;
    logic clk, rst_n, wr_s, rd_s, start, done, d;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, got;
    logic signed [11:0] raw;
    logic [15:0] ex;
    logic [5:0] c;
    logic [2:0] pc, nc;
    adc_sel_pkg::route_t route;
    adc_sel_pkg::reference_t refsel;
    logic int_ref, busy, dflag;
    int failures = 0, checks = 0, cycles = 0;
    row_t rows [12] = '{
        '{8'h00, 10'h028}, '{8'h27, 10'h3ff},
        '{8'h43, 10'h078}, '{8'h81, 10'h050},
        '{8'hc6, 10'h320}, '{8'hed, 10'h270},
        '{8'hcf, 10'h200}, '{8'hc8, 10'h000},
        '{8'hd4, 10'h0a0}, '{8'hdd, 10'h39c},
        '{8'hde, 10'h1e8}, '{8'hdf, 10'h000}};

    adc_select_format adc_select_format_i (.i_clk(clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
        .i_conv_start(start), .i_conv_done(done), .i_conv_raw(raw),
        .o_rdata(rdata), .o_route(route), .o_reference(refsel),
        .o_int_ref_enable(int_ref), .o_conv_busy(busy), .o_done_flag(dflag));
    adc_analog_model adc_analog_model_i (.i_clk(clk), .i_start(start),
        .i_route(route), .o_done(done), .o_raw(raw));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task tally_and_finish;
        if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task cmp8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk); wr_s <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk); wr_s <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk); rd_s <= 1'b1; addr <= a;
        @(posedge clk); rd_s <= 1'b0;
        #1 cmp8(rdata, e);
    endtask
    task go;
        @(posedge clk); start <= 1'b1;
        @(posedge clk); start <= 1'b0;
    endtask
    task wait_done;
        for (int k = 0; k < 40 && dflag !== 1'b1; k++) @(posedge clk);
        #1;
    endtask

    // A hung handshake ends the run as a failure.
    initial begin clk = 1'b0; forever #10 clk = ~clk; end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin failures++; tally_and_finish(); end
    end

    initial begin
        rst_n = 1'b0; wr_s = 1'b0; rd_s = 1'b0; start = 1'b0;
        addr = 4'h0; wdata = 8'h00;
        adc_analog_model_i.mv = '{100, 200, 500, 300, 1000, 0, 2000, 2600};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rdc(4'h0, 8'h00);
        foreach (rows[n]) begin
            wr(4'h0, rows[n].sel);
            rdc(4'h0, rows[n].sel);
            cmp8({6'h00, refsel}, {6'h00, rows[n].sel[7:6]});
            cmp8({7'h00, int_ref}, {7'h00, rows[n].sel[7:6] == 2'h3});
            go(); wait_done();
            ex = rows[n].sel[5] ? {rows[n].code, 6'h00}
                                : {6'h00, rows[n].code};
            rdc(4'h1, ex[7:0]);
            rdc(4'h2, ex[15:8]);
            rdc(4'h3, 8'h01);
            wr(4'h3, 8'h01);
        end
        rdc(4'h3, 8'h00);
        // Every channel code, checked at the routing outputs.
        for (c = 6'h00; c < 6'h20; c++) begin
            wr(4'h0, {3'h0, c[4:0]}); @(posedge clk); #1;
            d = c >= 6'h08 && c < 6'h1e;
            cmp8({5'h00, route.differential, route.bandgap, route.ground},
                {5'h00, d, c == 6'h1e, c == 6'h1f});
            if (c < 6'h08) begin
                cmp8({5'h00, route.pos_channel}, {5'h00, c[2:0]});
            end
            if (d) begin
                pc = c < 6'h10 ? {1'b0, c[2], c[0]} : c[2:0];
                nc = c < 6'h10 ? {1'b0, c[2], 1'b0} : (c < 6'h18 ? 3'h1 : 3'h2);
                cmp8({2'h0, route.pos_channel, route.neg_channel},
                    {2'h0, pc, nc});
                cmp8(route.gain,
                    c < 6'h10 ? (c[1] ? 8'hc8 : 8'h0a) : 8'h01);
            end
        end
        // Select rewrite mid conversion, then a done while the pair is locked.
        wr(4'h0, 8'h00); go(); wr(4'h0, 8'he7);
        #1 cmp8({6'h00, refsel}, 8'h00);
        cmp8({7'h00, busy}, 8'h01);
        rdc(4'h3, 8'h02);
        wait_done();
        rdc(4'h1, 8'h00);
        rdc(4'h3, 8'h05);
        cmp8({6'h00, refsel}, 8'h03);
        wr(4'h3, 8'h01); go(); wait_done();
        rdc(4'h2, 8'h0a);
        rdc(4'h1, 8'hc0);
        rdc(4'h2, 8'hff);
        wr(4'h0, 8'hc7);
        rdc(4'h1, 8'hff);
        rdc(4'h2, 8'h03);
        // Reset in mid-run, unmapped and read-only places.
        @(posedge clk); rst_n <= 1'b0;
        repeat (2) @(posedge clk); rst_n <= 1'b1;
        rdc(4'h0, 8'h00);
        rdc(4'h3, 8'h00);
        wr(4'hf, 8'h5a); wr(4'h1, 8'h55);
        rdc(4'hf, 8'h00);
        rdc(4'h1, 8'h00);
        tally_and_finish();
    end
endmodule
